// ===== tb/iec_top_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end
module iec_top_tb;
	import iec_pkg::*;
	logic CLK, RST_N, CTRL_BUSY, CTRL_ENABLED, PREADY, PSLVERR, TXF_HOLD, IRQ;
	iec_apb_req_s req;
	logic [31:0] PRDATA;
	logic [RAW_W-1:0] EVENT_SET, RAW_STATUS;
	logic [CAUSE_W-1:0] CAUSE_SET, ABORT_CAUSE;
	int bad_count = 0;
	int num_checks = 0;
	localparam logic [31:0] CA [7] = '{ADDR_CLEAR_RECEIVE_UNDERFLOW, ADDR_CLEAR_RECEIVE_OVERFLOW,
		ADDR_CLEAR_TRANSMIT_OVERFLOW, ADDR_CLEAR_READ_REQUEST, ADDR_CLEAR_RECEIVE_FINISHED,
		ADDR_CLEAR_STOP_SEEN, ADDR_CLEAR_START_SEEN};
	localparam int CB [7] = '{0, 1, 3, 5, 7, 9, 10};

	iec_top uut (.CLK(CLK), .RST_N(RST_N), .APB_IN(req), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .EVENT_SET(EVENT_SET), .CAUSE_SET(CAUSE_SET), .CTRL_BUSY(CTRL_BUSY),
		.CTRL_ENABLED(CTRL_ENABLED), .RAW_STATUS(RAW_STATUS), .ABORT_CAUSE(ABORT_CAUSE),
		.TXF_HOLD(TXF_HOLD), .IRQ(IRQ));

	initial begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end

	// ----------------------------------------
	// shared drivers
	// ----------------------------------------
	task end_of_test;
		if (bad_count == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_of_test

	task apb_xfer(input logic [31:0] a, input logic wr, input logic [31:0] wd,
		output logic [31:0] d, output logic e);
		int n;
		n = 0;
		@(posedge CLK);
		req.paddr <= a;
		req.pwrite <= wr;
		req.pwdata <= wd;
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		@(posedge CLK);
		req.penable <= 1'b1;
		do begin
			@(posedge CLK);
			n++;
		end while (PREADY !== 1'b1 && n < 50);
		if (n >= 50)
			bad_count++;
		d = PRDATA;
		e = PSLVERR;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask : apb_xfer

	task rd(input logic [31:0] a, output logic [31:0] d);
		logic e;
		apb_xfer(a, 1'b0, 32'h0000_0000, d, e);
	endtask : rd

	task wr(input logic [31:0] a, input logic [31:0] wd);
		logic [31:0] d;
		logic e;
		apb_xfer(a, 1'b1, wd, d, e);
	endtask : wr

	// one-cycle event pulse, returns once the raw status has landed
	task pulse(input logic [RAW_W-1:0] ev, input logic [CAUSE_W-1:0] ca);
		@(posedge CLK);
		EVENT_SET <= ev;
		CAUSE_SET <= ca;
		@(posedge CLK);
		EVENT_SET <= '0;
		CAUSE_SET <= '0;
		@(posedge CLK);
	endtask : pulse

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset;
		logic [31:0] d;
		`CHK("raw", 12'h000, RAW_STATUS)
		`CHK("hold", 1'b0, TXF_HOLD)
		`CHK("irq", 1'b0, IRQ)
		`CHK("pready", 1'b1, PREADY)
		`CHK("pslverr", 1'b0, PSLVERR)
		rd(ADDR_IRQ_ENABLE, d);
		`CHK("irq_en", 32'h0000_0000, d)
		for (int i = 0; i < 7; i++) begin
			rd(CA[i], d);
			`CHK("clr_rst", 32'h0000_0000, d)
		end
	endtask : t_reset

	task t_each;
		logic [31:0] d;
		for (int i = 0; i < 7; i++) begin
			pulse(SW_CLEAR_MASK, 16'h0000);
			rd(CA[i], d);
			`CHK("clr_data", 32'h0000_0001, d)
			@(posedge CLK);
			`CHK("raw_one", SW_CLEAR_MASK & ~(12'h001 << CB[i]), RAW_STATUS)
		end
	endtask : t_each

	task t_writes;
		pulse(SW_CLEAR_MASK, 16'h0000);
		for (int i = 0; i < 7; i++)
			wr(CA[i], 32'hFFFF_FFFF);
		wr(ADDR_CLEAR_TRANSMIT_ABORT, 32'hFFFF_FFFF);
		wr(ADDR_CLEAR_ALL_EVENTS, 32'hFFFF_FFFF);
		@(posedge CLK);
		`CHK("raw_wr", SW_CLEAR_MASK, RAW_STATUS)
	endtask : t_writes

	task t_abort;
		logic [31:0] d;
		pulse(12'h040, 16'hFFFF);
		`CHK("hold_set", 1'b1, TXF_HOLD)
		`CHK("cause_set", 16'hFFFF, ABORT_CAUSE)
		rd(ADDR_CLEAR_TRANSMIT_ABORT, d);
		`CHK("abort_data", 32'h0000_0001, d)
		@(posedge CLK);
		`CHK("abort_bit", 1'b0, RAW_STATUS[6])
		`CHK("cause_clr", 16'h0200, ABORT_CAUSE)
		`CHK("hold_clr", 1'b0, TXF_HOLD)
	endtask : t_abort

	task t_activity;
		logic [31:0] d;
		CTRL_BUSY <= 1'b1;
		pulse(12'h100, 16'h0000);
		rd(ADDR_CLEAR_BUS_ACTIVITY, d);
		`CHK("act_busy_d", 32'h0000_0001, d)
		@(posedge CLK);
		`CHK("act_busy", 1'b1, RAW_STATUS[8])
		CTRL_BUSY <= 1'b0;
		rd(ADDR_CLEAR_BUS_ACTIVITY, d);
		`CHK("act_idle_d", 32'h0000_0001, d)
		@(posedge CLK);
		`CHK("act_idle", 1'b0, RAW_STATUS[8])
		rd(ADDR_CLEAR_BUS_ACTIVITY, d);
		`CHK("act_zero_d", 32'h0000_0000, d)
		pulse(12'h100, 16'h0000);
		`CHK("act_set", 1'b1, RAW_STATUS[8])
		CTRL_ENABLED <= 1'b0;
		repeat (3) @(posedge CLK);
		`CHK("act_auto", 1'b0, RAW_STATUS[8])
		CTRL_ENABLED <= 1'b1;
	endtask : t_activity

	task t_combined;
		logic [31:0] d;
		pulse(SW_CLEAR_MASK, 16'hFFFF);
		rd(ADDR_CLEAR_ALL_EVENTS, d);
		`CHK("all_data", 32'h0000_0001, d)
		@(posedge CLK);
		`CHK("all_raw", 12'h000, RAW_STATUS)
		`CHK("all_cause", 16'h0200, ABORT_CAUSE)
		`CHK("all_hold", 1'b0, TXF_HOLD)
	endtask : t_combined

	task t_irq;
		logic [31:0] d;
		logic e;
		wr(ADDR_IRQ_CLEAR, 32'h0000_0FFF);
		wr(ADDR_IRQ_ENABLE, 32'h0000_0002);
		@(posedge CLK);
		`CHK("irq_idle", 1'b0, IRQ)
		pulse(12'h002, 16'h0000);
		`CHK("irq_on", 1'b1, IRQ)
		rd(ADDR_IRQ_STATUS, d);
		`CHK("irq_stat", 1'b1, d[1])
		wr(ADDR_IRQ_ENABLE, 32'h0000_0000);
		@(posedge CLK);
		`CHK("irq_mask", 1'b0, IRQ)
		wr(ADDR_IRQ_ENABLE, 32'h0000_0002);
		@(posedge CLK);
		`CHK("irq_unmask", 1'b1, IRQ)
		wr(ADDR_IRQ_CLEAR, 32'h0000_0002);
		@(posedge CLK);
		`CHK("irq_clr", 1'b0, IRQ)
		apb_xfer(32'h5000_13F0, 1'b0, 32'h0000_0000, d, e);
		`CHK("unmapped", 1'b1, e)
	endtask : t_irq

	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		req = '0;
		EVENT_SET = '0;
		CAUSE_SET = '0;
		CTRL_BUSY = 1'b0;
		CTRL_ENABLED = 1'b1;
		RST_N = 1'b0;
		repeat (5) @(posedge CLK);
		RST_N <= 1'b1;
		@(posedge CLK);
		t_reset;
		t_each;
		t_writes;
		t_abort;
		t_activity;
		t_combined;
		t_irq;
		end_of_test;
	end

	// whole run is well under a thousand cycles
	initial begin
		repeat (5000) @(posedge CLK);
		bad_count++;
		end_of_test;
	end
endmodule : iec_top_tb

// ===== verilog/iec_pkg.sv
package iec_pkg;
	// ----------------------------------------
	// bus and field widths
	// ----------------------------------------
	localparam int DATA_W = 32;
	localparam int RAW_W = 12;
	localparam int CAUSE_W = 16;

	// ----------------------------------------
	// clear-on-read registers (byte addresses)
	// ----------------------------------------
	localparam logic [31:0] ADDR_CLEAR_ALL_EVENTS = 32'h5000_1340;
	localparam logic [31:0] ADDR_CLEAR_RECEIVE_UNDERFLOW = 32'h5000_1344;
	localparam logic [31:0] ADDR_CLEAR_RECEIVE_OVERFLOW = 32'h5000_1348;
	localparam logic [31:0] ADDR_CLEAR_TRANSMIT_OVERFLOW = 32'h5000_134C;
	localparam logic [31:0] ADDR_CLEAR_READ_REQUEST = 32'h5000_1350;
	localparam logic [31:0] ADDR_CLEAR_TRANSMIT_ABORT = 32'h5000_1354;
	localparam logic [31:0] ADDR_CLEAR_RECEIVE_FINISHED = 32'h5000_1358;
	localparam logic [31:0] ADDR_CLEAR_BUS_ACTIVITY = 32'h5000_135C;
	localparam logic [31:0] ADDR_CLEAR_STOP_SEEN = 32'h5000_1360;
	localparam logic [31:0] ADDR_CLEAR_START_SEEN = 32'h5000_1364;

	// ----------------------------------------
	// status, cause and interrupt registers
	// ----------------------------------------
	localparam logic [31:0] ADDR_RAW_EVENT_STATUS = 32'h5000_1380;
	localparam logic [31:0] ADDR_ABORT_CAUSE = 32'h5000_1384;
	localparam logic [31:0] ADDR_IRQ_STATUS = 32'h5000_1388;
	localparam logic [31:0] ADDR_IRQ_CLEAR = 32'h5000_138C;
	localparam logic [31:0] ADDR_IRQ_ENABLE = 32'h5000_1390;

	// ----------------------------------------
	// raw event status bit positions
	// ----------------------------------------
	localparam int BIT_RX_UNDER = 0;
	localparam int BIT_RX_OVER = 1;
	localparam int BIT_TX_OVER = 3;
	localparam int BIT_RD_REQ = 5;
	localparam int BIT_TX_ABORT = 6;
	localparam int BIT_RX_DONE = 7;
	localparam int BIT_ACTIVITY = 8;
	localparam int BIT_STOP_SEEN = 9;
	localparam int BIT_START_SEEN = 10;
	localparam int CAUSE_KEEP_BIT = 9;

	localparam logic [RAW_W-1:0] SW_CLEAR_MASK = 12'h7EB;
	localparam logic [CAUSE_W-1:0] CAUSE_KEEP_MASK = 16'h0200;
	localparam logic [RAW_W-1:0] RAW_RESET = 12'h000;
	localparam logic [CAUSE_W-1:0] CAUSE_RESET = 16'h0000;
	localparam logic [RAW_W-1:0] IRQ_EN_RESET = 12'h000;
	localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;

	// ----------------------------------------
	// apb request from the master
	// ----------------------------------------
	typedef struct packed {
		logic [31:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} iec_apb_req_s;
endpackage : iec_pkg

// ===== verilog/iec_top.sv
// Local design decision: the APB register port.
`timescale 1ns/1ps
// Overview of operation
// - reading underflow clear resets raw bit 0
// - reading overflow clear resets raw bit 1
// - reading transmit-overflow clear resets raw bit 3
// - reading read-request clear resets raw bit 5
// - reading abort clear resets bit 6, cause
// - reading abort clear releases transmit fifo hold
// - abort-cause bit 9 survives the clear
// - reading receive-done clear resets raw bit 7
// - activity clears on read only when idle
// - activity self-clears when disabled and idle
// - activity clear read returns raw bit 8
// - reading stop clear resets raw bit 9
// - reading start clear resets raw bit 10
// - combined clear resets all software events except activity while busy, cause
module iec_top (
	input wire logic CLK,
	input wire logic RST_N,
	input wire iec_pkg::iec_apb_req_s APB_IN,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [iec_pkg::RAW_W-1:0] EVENT_SET,
	input wire logic [iec_pkg::CAUSE_W-1:0] CAUSE_SET,
	input wire logic CTRL_BUSY,
	input wire logic CTRL_ENABLED,
	output logic [iec_pkg::RAW_W-1:0] RAW_STATUS,
	output logic [iec_pkg::CAUSE_W-1:0] ABORT_CAUSE,
	output logic TXF_HOLD,
	output logic IRQ
);
	import iec_pkg::*;

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function automatic logic [31:0] clear_addr(input int idx);
		case (idx)
			BIT_RX_UNDER: clear_addr = ADDR_CLEAR_RECEIVE_UNDERFLOW;
			BIT_RX_OVER: clear_addr = ADDR_CLEAR_RECEIVE_OVERFLOW;
			BIT_TX_OVER: clear_addr = ADDR_CLEAR_TRANSMIT_OVERFLOW;
			BIT_RD_REQ: clear_addr = ADDR_CLEAR_READ_REQUEST;
			BIT_TX_ABORT: clear_addr = ADDR_CLEAR_TRANSMIT_ABORT;
			BIT_RX_DONE: clear_addr = ADDR_CLEAR_RECEIVE_FINISHED;
			BIT_ACTIVITY: clear_addr = ADDR_CLEAR_BUS_ACTIVITY;
			BIT_STOP_SEEN: clear_addr = ADDR_CLEAR_STOP_SEEN;
			BIT_START_SEEN: clear_addr = ADDR_CLEAR_START_SEEN;
			default: clear_addr = 32'hFFFF_FFFF;
		endcase
	endfunction : clear_addr

	function automatic logic addr_mapped(input logic [31:0] a);
		addr_mapped = (a >= ADDR_CLEAR_ALL_EVENTS && a <= ADDR_CLEAR_START_SEEN && a[1:0] == 2'h0) ||
			a == ADDR_RAW_EVENT_STATUS || a == ADDR_ABORT_CAUSE || a == ADDR_IRQ_STATUS ||
			a == ADDR_IRQ_CLEAR || a == ADDR_IRQ_ENABLE;
	endfunction : addr_mapped

	logic [RAW_W-1:0] raw;
	logic [CAUSE_W-1:0] cause;
	logic txf_hold;
	logic [RAW_W-1:0] irq_stat;
	logic [RAW_W-1:0] irq_en;
	logic [31:0] prdata;
	logic pslverr;
	logic setup;
	logic rd_access;
	logic wr_access;
	logic clear_all_hit;
	logic cause_clear;
	logic [RAW_W-1:0] raw_clear;
	logic [RAW_W-1:0] raw_set;
	logic [CAUSE_W-1:0] next_cause;
	logic [31:0] next_rdata;

	// ----------------------------------------
	// apb slave handshake
	// ----------------------------------------
	// registers answer with no wait states
	assign PREADY = 1'b1;
	assign setup = APB_IN.psel && !APB_IN.penable;
	assign rd_access = APB_IN.psel && APB_IN.penable && !APB_IN.pwrite;
	assign wr_access = APB_IN.psel && APB_IN.penable && APB_IN.pwrite;
	assign clear_all_hit = rd_access && APB_IN.paddr == ADDR_CLEAR_ALL_EVENTS;
	assign cause_clear = clear_all_hit || (rd_access && APB_IN.paddr == ADDR_CLEAR_TRANSMIT_ABORT);

	// ----------------------------------------
	// raw event status
	// ----------------------------------------
	// only software-clearable positions are held here; fifo level bits live elsewhere
	assign raw_set = EVENT_SET & SW_CLEAR_MASK;

	always_comb begin
		raw_clear = '0;
		for (int i = 0; i < RAW_W; i++) begin
			if (SW_CLEAR_MASK[i] && rd_access && (APB_IN.paddr == clear_addr(i) || clear_all_hit)) begin
				raw_clear[i] = 1'b1;
			end
		end
		// the controller may still own the bus; a read then leaves activity standing
		if (CTRL_BUSY) begin
			raw_clear[BIT_ACTIVITY] = 1'b0;
		end else if (!CTRL_ENABLED) begin
			raw_clear[BIT_ACTIVITY] = 1'b1;
		end
	end

	// set wins over clear so an event in the clearing cycle is kept
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			raw <= RAW_RESET;
		end else begin
			raw <= (raw & ~raw_clear) | raw_set;
		end
	end

	// ----------------------------------------
	// abort cause and transmit fifo hold
	// ----------------------------------------
	always_comb begin
		next_cause = cause;
		if (cause_clear) begin
			next_cause = cause & CAUSE_KEEP_MASK;
		end
		next_cause = next_cause | CAUSE_SET;
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			cause <= CAUSE_RESET;
		end else begin
			cause <= next_cause;
		end
	end

	// the fifo stays flushed from the abort until software acknowledges it
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			txf_hold <= 1'b0;
		end else if (EVENT_SET[BIT_TX_ABORT]) begin
			txf_hold <= 1'b1;
		end else if (cause_clear) begin
			txf_hold <= 1'b0;
		end
	end

	// ----------------------------------------
	// interrupt status, enable and clear
	// ----------------------------------------
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			irq_stat <= RAW_RESET;
		end else if (wr_access && APB_IN.paddr == ADDR_IRQ_CLEAR) begin
			irq_stat <= (irq_stat & ~APB_IN.pwdata[RAW_W-1:0]) | raw_set;
		end else begin
			irq_stat <= irq_stat | raw_set;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			irq_en <= IRQ_EN_RESET;
		end else if (wr_access && APB_IN.paddr == ADDR_IRQ_ENABLE) begin
			irq_en <= APB_IN.pwdata[RAW_W-1:0];
		end
	end

	// ----------------------------------------
	// read data, captured in the setup cycle
	// ----------------------------------------
	always_comb begin
		next_rdata = '0;
		case (APB_IN.paddr)
			ADDR_CLEAR_ALL_EVENTS: next_rdata[0] = |raw;
			ADDR_CLEAR_BUS_ACTIVITY: next_rdata[0] = raw[BIT_ACTIVITY];
			ADDR_RAW_EVENT_STATUS: next_rdata[RAW_W-1:0] = raw;
			ADDR_ABORT_CAUSE: next_rdata[CAUSE_W-1:0] = cause;
			ADDR_IRQ_STATUS: next_rdata[RAW_W-1:0] = irq_stat;
			ADDR_IRQ_ENABLE: next_rdata[RAW_W-1:0] = irq_en;
			default: begin
				for (int i = 0; i < RAW_W; i++) begin
					if (SW_CLEAR_MASK[i] && APB_IN.paddr == clear_addr(i)) begin
						next_rdata[0] = raw[i];
					end
				end
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			prdata <= RDATA_RESET;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata <= APB_IN.pwrite ? RDATA_RESET : next_rdata;
			pslverr <= !addr_mapped(APB_IN.paddr);
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign PRDATA = prdata;
	assign PSLVERR = pslverr;
	assign RAW_STATUS = raw;
	assign ABORT_CAUSE = cause;
	assign TXF_HOLD = txf_hold;
	assign IRQ = |(irq_stat & irq_en);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	sequence rd_at(logic [31:0] a);
		APB_IN.psel && APB_IN.penable && !APB_IN.pwrite && APB_IN.paddr == a;
	endsequence

	sequence setup_at(logic [31:0] a);
		APB_IN.psel && !APB_IN.penable && !APB_IN.pwrite && APB_IN.paddr == a;
	endsequence

	underflow_clear_a: assert property (rd_at(ADDR_CLEAR_RECEIVE_UNDERFLOW) and !EVENT_SET[BIT_RX_UNDER]
		|=> !RAW_STATUS[BIT_RX_UNDER]) else $error("underflow not cleared by read");
	overflow_clear_a: assert property (rd_at(ADDR_CLEAR_RECEIVE_OVERFLOW) and !EVENT_SET[BIT_RX_OVER]
		|=> !RAW_STATUS[BIT_RX_OVER]) else $error("overflow not cleared by read");
	tx_over_clear_a: assert property (rd_at(ADDR_CLEAR_TRANSMIT_OVERFLOW) and !EVENT_SET[BIT_TX_OVER]
		|=> !RAW_STATUS[BIT_TX_OVER]) else $error("tx overflow not cleared by read");
	rd_req_clear_a: assert property (rd_at(ADDR_CLEAR_READ_REQUEST) and !EVENT_SET[BIT_RD_REQ]
		|=> !RAW_STATUS[BIT_RD_REQ]) else $error("read request not cleared by read");
	abort_clear_a: assert property (rd_at(ADDR_CLEAR_TRANSMIT_ABORT) and !EVENT_SET[BIT_TX_ABORT] and CAUSE_SET == '0
		|=> !RAW_STATUS[BIT_TX_ABORT] && (ABORT_CAUSE & ~CAUSE_KEEP_MASK) == '0)
		else $error("abort event or cause not cleared");
	fifo_release_a: assert property (rd_at(ADDR_CLEAR_TRANSMIT_ABORT) and !EVENT_SET[BIT_TX_ABORT]
		|=> !TXF_HOLD) else $error("tx fifo still held after abort clear");
	cause_keep_a: assert property (rd_at(ADDR_CLEAR_TRANSMIT_ABORT) and !CAUSE_SET[CAUSE_KEEP_BIT]
		|=> ABORT_CAUSE[CAUSE_KEEP_BIT] == $past(ABORT_CAUSE[CAUSE_KEEP_BIT]))
		else $error("kept cause bit changed by clear");
	rx_done_clear_a: assert property (rd_at(ADDR_CLEAR_RECEIVE_FINISHED) and !EVENT_SET[BIT_RX_DONE]
		|=> !RAW_STATUS[BIT_RX_DONE]) else $error("receive done not cleared by read");
	busy_keep_a: assert property (rd_at(ADDR_CLEAR_BUS_ACTIVITY) and CTRL_BUSY and RAW_STATUS[BIT_ACTIVITY]
		|=> RAW_STATUS[BIT_ACTIVITY]) else $error("activity cleared while busy");
	auto_idle_a: assert property (!CTRL_ENABLED && !CTRL_BUSY && !EVENT_SET[BIT_ACTIVITY]
		|=> !RAW_STATUS[BIT_ACTIVITY]) else $error("activity not cleared when idle and disabled");
	activity_read_a: assert property (setup_at(ADDR_CLEAR_BUS_ACTIVITY)
		|=> PRDATA[0] == $past(RAW_STATUS[BIT_ACTIVITY]) && PRDATA[31:1] == '0)
		else $error("activity read value wrong");
	stop_clear_a: assert property (rd_at(ADDR_CLEAR_STOP_SEEN) and !EVENT_SET[BIT_STOP_SEEN]
		|=> !RAW_STATUS[BIT_STOP_SEEN]) else $error("stop seen not cleared by read");
	start_clear_a: assert property (rd_at(ADDR_CLEAR_START_SEEN) and !EVENT_SET[BIT_START_SEEN]
		|=> !RAW_STATUS[BIT_START_SEEN]) else $error("start seen not cleared by read");
	clear_all_a: assert property (rd_at(ADDR_CLEAR_ALL_EVENTS) and EVENT_SET == '0 and CAUSE_SET == '0
		|=> (RAW_STATUS & SW_CLEAR_MASK & ~(12'h001 << BIT_ACTIVITY)) == '0 &&
		(ABORT_CAUSE & ~CAUSE_KEEP_MASK) == '0) else $error("combined clear incomplete");
	write_ignored_a: assert property (APB_IN.psel && APB_IN.penable && APB_IN.pwrite &&
		APB_IN.paddr == ADDR_CLEAR_RECEIVE_UNDERFLOW && RAW_STATUS[BIT_RX_UNDER]
		|=> RAW_STATUS[BIT_RX_UNDER]) else $error("write cleared an event");

	// ----------------------------------------
	// checks: bus side
	// ----------------------------------------
	sequence wr_at(logic [31:0] a);
		APB_IN.psel && APB_IN.penable && APB_IN.pwrite && APB_IN.paddr == a;
	endsequence

	// no event or cause pulse in the same cycle, so any change must come from the bus
	sequence quiet_events;
		EVENT_SET == '0 && CAUSE_SET == '0;
	endsequence

	ready_high_a: assert property (PREADY)
		else $error("slave inserted a wait state");

	unmapped_err_a: assert property (APB_IN.psel && !APB_IN.penable && !addr_mapped(APB_IN.paddr)
		|=> PSLVERR) else $error("unmapped address not flagged");

	mapped_ok_a: assert property (APB_IN.psel && !APB_IN.penable && addr_mapped(APB_IN.paddr)
		|=> !PSLVERR) else $error("mapped address flagged as error");

	clear_upper_a: assert property (APB_IN.psel && !APB_IN.penable && APB_IN.paddr >= ADDR_CLEAR_ALL_EVENTS &&
		APB_IN.paddr <= ADDR_CLEAR_START_SEEN |=> PRDATA[31:1] == '0)
		else $error("clear register upper bits not zero");

	write_rdata_a: assert property (APB_IN.psel && !APB_IN.penable && APB_IN.pwrite
		|=> PRDATA == '0) else $error("write returned read data");

	all_read_a: assert property (setup_at(ADDR_CLEAR_ALL_EVENTS)
		|=> PRDATA == {31'h0, $past(|RAW_STATUS)}) else $error("combined clear read value wrong");

	under_read_a: assert property (setup_at(ADDR_CLEAR_RECEIVE_UNDERFLOW)
		|=> PRDATA[0] == $past(RAW_STATUS[BIT_RX_UNDER])) else $error("underflow read value wrong");

	stop_read_a: assert property (setup_at(ADDR_CLEAR_STOP_SEEN)
		|=> PRDATA[0] == $past(RAW_STATUS[BIT_STOP_SEEN])) else $error("stop read value wrong");

	abort_write_a: assert property (wr_at(ADDR_CLEAR_TRANSMIT_ABORT) and quiet_events
		|=> $stable(ABORT_CAUSE) && $stable(TXF_HOLD)) else $error("write to abort clear acted");

	all_write_a: assert property (wr_at(ADDR_CLEAR_ALL_EVENTS) and quiet_events and CTRL_ENABLED
		|=> $stable(RAW_STATUS) && $stable(ABORT_CAUSE)) else $error("write to combined clear acted");

	// ----------------------------------------
	// checks: event side and interrupt
	// ----------------------------------------
	raw_set_a: assert property (raw_set != '0
		|=> (RAW_STATUS & $past(raw_set)) == $past(raw_set)) else $error("event lost in raw status");

	raw_hold_a: assert property (!rd_access && CTRL_ENABLED && EVENT_SET == '0
		|=> RAW_STATUS == $past(RAW_STATUS)) else $error("raw status changed with no read");

	unused_zero_a: assert property ((RAW_STATUS & ~SW_CLEAR_MASK) == '0)
		else $error("unused raw position set");

	cause_set_a: assert property (CAUSE_SET != '0
		|=> (ABORT_CAUSE & $past(CAUSE_SET)) == $past(CAUSE_SET)) else $error("cause pulse lost");

	cause_hold_a: assert property (!cause_clear && CAUSE_SET == '0
		|=> $stable(ABORT_CAUSE)) else $error("cause changed with no clear");

	hold_set_a: assert property (EVENT_SET[BIT_TX_ABORT]
		|=> TXF_HOLD) else $error("tx fifo not held after abort");

	busy_all_a: assert property (rd_at(ADDR_CLEAR_ALL_EVENTS) and CTRL_BUSY and RAW_STATUS[BIT_ACTIVITY]
		|=> RAW_STATUS[BIT_ACTIVITY]) else $error("combined clear dropped activity while busy");

	irq_sticky_a: assert property (raw_set != '0
		|=> (irq_stat & $past(raw_set)) == $past(raw_set)) else $error("interrupt status missed event");

	irq_clear_a: assert property (wr_at(ADDR_IRQ_CLEAR) and quiet_events
		|=> (irq_stat & $past(APB_IN.pwdata[RAW_W-1:0])) == '0) else $error("interrupt status not cleared");

	irq_enable_a: assert property (wr_at(ADDR_IRQ_ENABLE)
		|=> irq_en == $past(APB_IN.pwdata[RAW_W-1:0])) else $error("interrupt enable not written");
endmodule : iec_top
